// ===== src/tad_ais_top.sv
// alarm indication generation and detection with axi4-lite registers
//
// Notes on behaviour
// - transmit select 00 or 10 passes ordinary traffic unchanged.
// - transmit select 01 sends all ones, framing bits included.
// - transmit select 11 keeps framing bits, payload positions forced to one.
// - detect criteria 00 or 10 disables detection; defect never declared.
// - criteria 01 declares defect on unframed or framed all-ones.
// - criteria 11 declares defect only for framed all-ones.
`timescale 1ns/1ps
`default_nettype none
`include "tad_params.svh"

module tad_ais_top
	import tad_pkg::*;
#(
	parameter int WIN_BITS = `TAD_WIN_BITS_DEF
)
(
	input  wire logic        SYS_CLK,
	input  wire logic        SRST,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        TX_IN_DATA,
	input  wire logic        TX_IN_VALID,
	input  wire logic        TX_IN_FBIT,
	output logic             TX_OUT_DATA,
	output logic             TX_OUT_VALID,
	input  wire logic        RX_IN_DATA,
	input  wire logic        RX_IN_VALID,
	input  wire logic        RX_IN_FBIT,
	input  wire logic        RX_IN_SYNC,
	output logic             AIS_DEFECT,
	output logic             IRQ
);

	// register state
	logic [`TAD_CTRL_W-1:0] ctrl_r;
	logic [`TAD_CTRL_W-1:0] ctrl_nxt;
	logic [`TAD_INT_W-1:0]  int_stat_r;
	logic [`TAD_INT_W-1:0]  int_stat_nxt;
	logic [`TAD_INT_W-1:0]  int_mask_r;
	logic [`TAD_INT_W-1:0]  int_mask_nxt;
	logic                   irq_r;
	logic                   irq_nxt;
	logic                   defect_prev_r;

	// write channel state
	logic                   aw_held_r;
	logic                   aw_held_nxt;
	logic [5:0]             aw_idx_r;
	logic [5:0]             aw_idx_nxt;
	logic                   w_held_r;
	logic                   w_held_nxt;
	logic [31:0]            w_data_r;
	logic [31:0]            w_data_nxt;
	logic                   w_lane0_r;
	logic                   w_lane0_nxt;
	logic                   awready_r;
	logic                   awready_nxt;
	logic                   wready_r;
	logic                   wready_nxt;
	logic                   bvalid_r;
	logic                   bvalid_nxt;
	logic [1:0]             bresp_r;
	logic [1:0]             bresp_nxt;

	// read channel state
	logic                   arready_r;
	logic                   arready_nxt;
	logic                   rvalid_r;
	logic                   rvalid_nxt;
	logic [31:0]            rdata_r;
	logic [31:0]            rdata_nxt;
	logic [1:0]             rresp_r;
	logic [1:0]             rresp_nxt;

	// transmit path state
	logic                   tx_data_r;
	logic                   tx_data_nxt;
	logic                   tx_valid_r;
	logic                   tx_valid_nxt;

	logic                   defect;
	logic                   do_write;
	logic [1:0]             ev_set;
	logic [1:0]             w1c;

	tad_sel_t               tx_sel;
	tad_sel_t               rx_crit;

	assign tx_sel = ctrl_r[`TAD_TXSEL_HI:`TAD_TXSEL_LO];
	assign rx_crit = ctrl_r[`TAD_RXCRIT_HI:`TAD_RXCRIT_LO];

	// refuse a window the bit counter cannot serve
	generate
		if (WIN_BITS < 2)
		begin : g_win_chk
			$error("WIN_BITS must be at least 2");
		end
	endgenerate

	function automatic logic idx_mapped(input logic [5:0] idx);
		return (idx == `TAD_OFF_ALARM_GEN) || (idx == `TAD_OFF_STATUS) ||
			(idx == `TAD_OFF_INT_STAT) || (idx == `TAD_OFF_INT_MASK);
	endfunction

	tad_ais_detect #(
		.WIN_BITS (WIN_BITS)
	) u_detect (
		.clk       (SYS_CLK),
		.srst      (SRST),
		.bit_valid (RX_IN_VALID),
		.bit_data  (RX_IN_DATA),
		.fbit_pos  (RX_IN_FBIT),
		.in_sync   (RX_IN_SYNC),
		.criteria  (rx_crit),
		.defect    (defect)
	);

	// write address and data taken in either order
	always_comb
	begin
		aw_held_nxt = aw_held_r;
		aw_idx_nxt = aw_idx_r;
		w_held_nxt = w_held_r;
		w_data_nxt = w_data_r;
		w_lane0_nxt = w_lane0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		do_write = 1'b0;
		if (S_AXI_AWVALID && awready_r)
		begin
			aw_held_nxt = 1'b1;
			aw_idx_nxt = S_AXI_AWADDR[7:2];
		end
		if (S_AXI_WVALID && wready_r)
		begin
			w_held_nxt = 1'b1;
			w_data_nxt = S_AXI_WDATA;
			w_lane0_nxt = S_AXI_WSTRB[0];
		end
		if (bvalid_r && S_AXI_BREADY)
		begin
			bvalid_nxt = 1'b0;
		end
		if (aw_held_r && w_held_r && !bvalid_r)
		begin
			do_write = 1'b1;
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = idx_mapped(aw_idx_r) ? `TAD_RESP_OKAY : `TAD_RESP_SLVERR;
		end
		awready_nxt = !aw_held_nxt && !bvalid_nxt;
		wready_nxt = !w_held_nxt && !bvalid_nxt;
	end

	// one read at a time, answer one cycle after address
	always_comb
	begin
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && S_AXI_RREADY)
		begin
			rvalid_nxt = 1'b0;
			arready_nxt = 1'b1;
		end
		if (!rvalid_r && !arready_r)
		begin
			arready_nxt = 1'b1;
		end
		if (S_AXI_ARVALID && arready_r)
		begin
			arready_nxt = 1'b0;
			rvalid_nxt = 1'b1;
			rresp_nxt = `TAD_RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			case (S_AXI_ARADDR[7:2])
				`TAD_OFF_ALARM_GEN: rdata_nxt[`TAD_CTRL_W-1:0] = ctrl_r;
				`TAD_OFF_STATUS: rdata_nxt[0] = defect;
				`TAD_OFF_INT_STAT: rdata_nxt[`TAD_INT_W-1:0] = int_stat_r;
				`TAD_OFF_INT_MASK: rdata_nxt[`TAD_INT_W-1:0] = int_mask_r;
				default: rresp_nxt = `TAD_RESP_SLVERR;
			endcase
		end
	end

	// control, mask and sticky event bits
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		int_mask_nxt = int_mask_r;
		w1c = 2'h0;
		ev_set[`TAD_INT_DECLARE] = defect & ~defect_prev_r;
		ev_set[`TAD_INT_CLEAR] = ~defect & defect_prev_r;
		if (do_write && w_lane0_r)
		begin
			case (aw_idx_r)
				`TAD_OFF_ALARM_GEN: ctrl_nxt = w_data_r[`TAD_CTRL_W-1:0];
				`TAD_OFF_INT_STAT: w1c = w_data_r[`TAD_INT_W-1:0];
				`TAD_OFF_INT_MASK: int_mask_nxt = w_data_r[`TAD_INT_W-1:0];
				default: ctrl_nxt = ctrl_r;
			endcase
		end
		// new event wins over a clear in the same cycle
		int_stat_nxt = (int_stat_r & ~w1c) | ev_set;
		irq_nxt = |(int_stat_nxt & int_mask_nxt);
	end

	// outgoing pattern substitution
	always_comb
	begin
		tx_valid_nxt = TX_IN_VALID;
		tx_data_nxt = tx_data_r;
		if (TX_IN_VALID)
		begin
			tx_data_nxt = tad_tx_bit(tx_sel, TX_IN_FBIT, TX_IN_DATA);
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (SRST)
		begin
			ctrl_r <= `TAD_CTRL_RST;
			int_stat_r <= `TAD_INT_RST;
			int_mask_r <= `TAD_INT_RST;
			irq_r <= 1'b0;
			defect_prev_r <= 1'b0;
			aw_held_r <= 1'b0;
			aw_idx_r <= 6'h00;
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_lane0_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `TAD_RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `TAD_RESP_OKAY;
			tx_data_r <= 1'b0;
			tx_valid_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			int_stat_r <= int_stat_nxt;
			int_mask_r <= int_mask_nxt;
			irq_r <= irq_nxt;
			defect_prev_r <= defect;
			aw_held_r <= aw_held_nxt;
			aw_idx_r <= aw_idx_nxt;
			w_held_r <= w_held_nxt;
			w_data_r <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			tx_data_r <= tx_data_nxt;
			tx_valid_r <= tx_valid_nxt;
		end
	end

	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY = wready_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;
	assign TX_OUT_DATA = tx_data_r;
	assign TX_OUT_VALID = tx_valid_r;
	assign AIS_DEFECT = defect;
	assign IRQ = irq_r;

endmodule

`default_nettype wire

// ===== include/tad_params.svh
// offsets, field positions and reset values of the alarm indication block
`ifndef TAD_PARAMS_SVH
`define TAD_PARAMS_SVH

`define TAD_OFF_ALARM_GEN   6'h00
`define TAD_OFF_STATUS      6'h01
`define TAD_OFF_INT_STAT    6'h02
`define TAD_OFF_INT_MASK    6'h03

`define TAD_CTRL_W          8
`define TAD_CTRL_RST        8'h00
`define TAD_TXSEL_HI        3
`define TAD_TXSEL_LO        2
`define TAD_RXCRIT_HI       1
`define TAD_RXCRIT_LO       0

`define TAD_INT_W           2
`define TAD_INT_DECLARE     0
`define TAD_INT_CLEAR       1
`define TAD_INT_RST         2'h0

`define TAD_WIN_BITS_DEF    2316

`define TAD_RESP_OKAY       2'h0
`define TAD_RESP_SLVERR     2'h2

`endif

// ===== include/tad_pkg.sv
// types and decode functions of the alarm indication block
`default_nettype none

package tad_pkg;

	typedef logic [1:0] tad_sel_t;

	// outgoing bit for a given transmit pattern select
	function automatic logic tad_tx_bit(input tad_sel_t sel, input logic fbit, input logic data);
		logic b;
		b = data;
		case (sel)
			2'h1: b = 1'b1;
			2'h3: b = fbit ? data : 1'b1;
			default: b = data;
		endcase
		return b;
	endfunction

	// defect decision for given criteria and window result
	function automatic logic tad_declare(input tad_sel_t crit, input logic unframed,
		input logic framed);
		logic d;
		d = 1'b0;
		case (crit)
			2'h1: d = unframed | framed;
			2'h3: d = framed;
			default: d = 1'b0;
		endcase
		return d;
	endfunction

endpackage

`default_nettype wire

// ===== src/tad_ais_detect.sv
// receive all-ones pattern detector over a window of line bits
`timescale 1ns/1ps
`default_nettype none
`include "tad_params.svh"

module tad_ais_detect
	import tad_pkg::*;
#(
	parameter int WIN_BITS = `TAD_WIN_BITS_DEF
)
(
	input  wire logic     clk,
	input  wire logic     srst,
	input  wire logic     bit_valid,
	input  wire logic     bit_data,
	input  wire logic     fbit_pos,
	input  wire logic     in_sync,
	input  wire tad_sel_t criteria,
	output logic          defect
);

	localparam int CW = $clog2(WIN_BITS);

	generate
		if (WIN_BITS < 2)
		begin : g_chk
			$error("WIN_BITS must be at least 2");
		end
	endgenerate

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          pz_r;
	logic          pz_nxt;
	logic          fz_r;
	logic          fz_nxt;
	logic          defect_r;
	logic          defect_nxt;

	always_comb
	begin
		logic pz_now;
		logic fz_now;
		logic unframed;
		logic framed;
		pz_now = pz_r | (bit_valid & ~fbit_pos & ~bit_data);
		fz_now = fz_r | (bit_valid & fbit_pos & ~bit_data);
		// every bit one, framing positions included
		unframed = ~pz_now & ~fz_now;
		// payload ones while framing still carries zeros and is aligned
		framed = ~pz_now & fz_now & in_sync;
		cnt_nxt = cnt_r;
		pz_nxt = pz_r;
		fz_nxt = fz_r;
		defect_nxt = defect_r;
		if (bit_valid)
		begin
			if (cnt_r == CW'(WIN_BITS - 1))
			begin
				cnt_nxt = '0;
				pz_nxt = 1'b0;
				fz_nxt = 1'b0;
				defect_nxt = tad_declare(criteria, unframed, framed);
			end
			else
			begin
				cnt_nxt = cnt_r + 1'b1;
				pz_nxt = pz_now;
				fz_nxt = fz_now;
			end
		end
		if (criteria[0] == 1'b0)
		begin
			defect_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_r <= '0;
			pz_r <= 1'b0;
			fz_r <= 1'b0;
			defect_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			pz_r <= pz_nxt;
			fz_r <= fz_nxt;
			defect_r <= defect_nxt;
		end
	end

	assign defect = defect_r;

endmodule

`default_nettype wire

// ===== testbench/tad_ais_sva.sv
// concurrent checks on the alarm indication block ports
`timescale 1ns/1ps
`default_nettype none
module tad_ais_sva
(
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic TX_IN_VALID,
	input wire logic TX_OUT_VALID,
	input wire logic TX_OUT_DATA,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic RX_IN_VALID,
	input wire logic AIS_DEFECT
);
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (SRST);
	tx_echo_a: assert property (TX_IN_VALID |=> TX_OUT_VALID)
		else $error("tx strobe not echoed");
	tx_idle_a: assert property (!TX_IN_VALID |=> !TX_OUT_VALID)
		else $error("tx valid without strobe");
	tx_hold_a: assert property (!TX_IN_VALID |=> $stable(TX_OUT_DATA))
		else $error("tx bit moved without strobe");
	wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
		S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write answer late");
	aw_busy_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
		else $error("address ready stayed high");
	b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
		else $error("read response dropped");
	defect_rise_a: assert property ($rose(AIS_DEFECT) |-> $past(RX_IN_VALID))
		else $error("defect rose off a bit strobe");
endmodule
bind tad_ais_top tad_ais_sva chk_u (.SYS_CLK, .SRST, .TX_IN_VALID, .TX_OUT_VALID, .TX_OUT_DATA,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
	.S_AXI_BREADY, .S_AXI_RVALID, .S_AXI_RREADY, .RX_IN_VALID, .AIS_DEFECT);
`default_nettype wire

// ===== testbench/tad_remote_term.sv
// remote terminal model sending the receive line stream
`timescale 1ns/1ps
`default_nettype none
module tad_remote_term
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [1:0] mode,
	output logic            rx_data,
	output logic            rx_valid,
	output logic            rx_fbit,
	output logic            rx_sync
);
	logic [2:0] pos_r;
	always_ff @(posedge clk)
	begin
		pos_r <= srst ? 3'h0 : pos_r + 3'h1;
	end
	// mode 0 traffic, 1 unframed ones, 2 framed ones
	assign rx_valid = !srst;
	assign rx_fbit  = pos_r[1:0] == 2'h0;
	assign rx_sync  = mode != 2'h1;
	assign rx_data  = mode == 2'h1 ? 1'h1 : mode == 2'h2 ? (!rx_fbit | pos_r[2]) : pos_r[0];
endmodule
`default_nettype wire

// ===== testbench/tad_ais_top_tb_top.sv
// self-checking bench of the alarm indication block
`timescale 1ns/1ps
`default_nettype none
module tad_ais_top_tb_top;
	localparam logic [4:0] RXT [7] = '{5'h0b, 5'h13, 5'h0e, 5'h17, 5'h06, 5'h10, 5'h14};
	logic        SYS_CLK = 1'h0;
	logic        SRST = 1'h1;
	logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0]  S_AXI_WSTRB = 4'hf;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, mode = 2'h0;
	logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, TX_IN_VALID = 1'h0;
	logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic        TX_IN_DATA = 1'h0, TX_IN_FBIT = 1'h0, TX_OUT_DATA, TX_OUT_VALID;
	logic        RX_IN_DATA, RX_IN_VALID, RX_IN_FBIT, RX_IN_SYNC, AIS_DEFECT, IRQ;
	int          n_mismatch = 0, checked = 0;

	always #10 SYS_CLK = ~SYS_CLK;

	tad_ais_top #(.WIN_BITS(16)) dut_u (.SYS_CLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID,
		.S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
		.S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
		.S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
		.TX_IN_DATA, .TX_IN_VALID, .TX_IN_FBIT, .TX_OUT_DATA, .TX_OUT_VALID, .RX_IN_DATA,
		.RX_IN_VALID, .RX_IN_FBIT, .RX_IN_SYNC, .AIS_DEFECT, .IRQ);
	tad_remote_term far_u (.clk(SYS_CLK), .srst(SRST), .mode, .rx_data(RX_IN_DATA),
		.rx_valid(RX_IN_VALID), .rx_fbit(RX_IN_FBIT), .rx_sync(RX_IN_SYNC));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'h1;
		w = 1'h1;
		@(posedge SYS_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		do
		begin
			@(posedge SYS_CLK);
			aw = aw && !S_AXI_AWREADY;
			w = w && !S_AXI_WREADY;
			S_AXI_AWVALID <= aw;
			S_AXI_WVALID <= w;
		end
		while (!S_AXI_BVALID);
		S_AXI_BREADY <= 1'h0;
		chk(S_AXI_BRESP, er, "write response");
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
		input string nm);
		@(posedge SYS_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do
		begin
			@(posedge SYS_CLK);
			if (S_AXI_ARREADY)
				S_AXI_ARVALID <= 1'h0;
		end
		while (!S_AXI_RVALID);
		S_AXI_RREADY <= 1'h0;
		chk(S_AXI_RDATA, ed, nm);
		chk(S_AXI_RRESP, er, "read response");
	endtask

	initial
	begin
		repeat (8) @(posedge SYS_CLK);
		SRST <= 1'h0;
		rd(8'h00, 32'h0, 2'h0, "control reset");
		rd(8'h0c, 32'h0, 2'h0, "mask reset");
		wr(8'h00, 32'ha5, 2'h0);
		rd(8'h00, 32'ha5, 2'h0, "control readback");
		S_AXI_WSTRB <= 4'he;
		wr(8'h00, 32'h5a, 2'h0);
		S_AXI_WSTRB <= 4'hf;
		rd(8'h00, 32'ha5, 2'h0, "lane zero off");
		wr(8'h10, 32'h1, 2'h2);
		rd(8'h10, 32'h0, 2'h2, "unmapped");
		$display("register test done");
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h00, 32'(s << 2), 2'h0);
			for (int i = 0; i < 4; i++)
			begin
				@(posedge SYS_CLK);
				TX_IN_VALID <= 1'h1;
				TX_IN_DATA <= i[0];
				TX_IN_FBIT <= i[1];
				@(posedge SYS_CLK);
				TX_IN_VALID <= 1'h0;
				@(negedge SYS_CLK);
				chk(TX_OUT_VALID, 1'h1, "tx valid");
				chk(TX_OUT_DATA, (s == 1 || (s == 3 && !i[1])) ? 1'h1 : i[0], "tx bit");
			end
		end
		$display("transmit test done");
		for (int k = 0; k < 7; k++)
		begin
			mode <= RXT[k][4:3];
			wr(8'h00, {30'h0, RXT[k][2:1]}, 2'h0);
			repeat (40) @(posedge SYS_CLK);
			chk(AIS_DEFECT, RXT[k][0], "defect");
			rd(8'h04, {31'h0, RXT[k][0]}, 2'h0, "status");
		end
		$display("receive test done");
		wr(8'h08, 32'h3, 2'h0);
		wr(8'h0c, 32'h1, 2'h0);
		mode <= 2'h1;
		wr(8'h00, 32'h1, 2'h0);
		repeat (40) @(posedge SYS_CLK);
		chk(IRQ, 1'h1, "irq raised");
		wr(8'h0c, 32'h0, 2'h0);
		repeat (2) @(posedge SYS_CLK);
		chk(IRQ, 1'h0, "irq masked");
		rd(8'h08, 32'h1, 2'h0, "event status");
		wr(8'h08, 32'h1, 2'h0);
		rd(8'h08, 32'h0, 2'h0, "event cleared");
		wr(8'h0c, 32'h3, 2'h0);
		repeat (2) @(posedge SYS_CLK);
		chk(IRQ, 1'h0, "irq after clear");
		mode <= 2'h0;
		repeat (40) @(posedge SYS_CLK);
		chk(AIS_DEFECT, 1'h0, "defect dropped");
		chk(IRQ, 1'h1, "irq on clear event");
		rd(8'h08, 32'h2, 2'h0, "clear event status");
		rd(8'h04, 32'h0, 2'h0, "status dropped");
		$display("interrupt test done");
		summarize();
	end

	initial
	begin
		repeat (20000) @(posedge SYS_CLK);
		n_mismatch++;
		summarize();
	end
endmodule
`default_nettype wire
